// ==== rtl/nmt_lss_node_handler.sv ====
`timescale 1ns/10ps
`include "nmt_lss_params.svh"
module nmt_lss_node_handler
    import nmt_lss_pkg::*;
(
    input wire logic clk_i, // Clock, 20 MHz
    input wire logic rst_i, // Sync reset, active high
    input wire logic rx_valid_i, // Received frame strobe
    input wire nmt_lss_pkg::can_frame_type rx_frame_i, // Received frame
    input wire logic tx_ready_i, // Transmitter took tx frame
    input wire nmt_lss_pkg::layer_cfg_type nv_cfg_i, // Stored settings
    input wire logic nv_done_i, // Store finished
    input wire logic nv_fail_i, // Store failed
    input wire logic hb_enabled_i, // Guarding/heartbeat configured
    output nmt_lss_pkg::can_frame_type tx_frame_o, // Reply frame
    output logic tx_valid_o, // Reply pending
    output nmt_lss_pkg::nmt_state_type state_o, // Current state
    output nmt_lss_pkg::comm_enable_type comm_en_o, // Object enables
    output logic [6:0] node_id_o, // Active node id
    output logic [2:0] rate_idx_o, // Active bit rate index
    output logic nv_write_o, // Store request level
    output nmt_lss_pkg::layer_cfg_type nv_wdata_o, // Data to store
    output logic app_reset_o, // Application reset pulse
    output logic comm_reset_o, // Communication reset pulse
    output logic lss_config_o // Configuration state flag
);
    import nmt_lss_pkg::*;

    logic [7:0] b0, b1, b2;
    logic is_nmt, is_lss, nmt_for_me, nmt_reset;
    logic [15:0] init_cnt_q;
    layer_cfg_type pend_q;
    logic load_q;
    logic timer_done;
    logic timer_start;

    frame_field #(.INDEX(0)) u_b0 (.data_i(rx_frame_i.data), .byte_o(b0));
    frame_field #(.INDEX(1)) u_b1 (.data_i(rx_frame_i.data), .byte_o(b1));
    frame_field #(.INDEX(2)) u_b2 (.data_i(rx_frame_i.data), .byte_o(b2));

    // Initialization drops every frame since the node does not communicate yet
    assign is_nmt = rx_valid_i && state_o != ST_INIT && rx_frame_i.id == `NMT_ID
                    && rx_frame_i.dlc == `NMT_DLC;
    assign nmt_for_me = is_nmt && (b1 == `NMT_ALL_NODES || b1 == {1'b0, node_id_o});
    assign nmt_reset = nmt_for_me && (b0 == `NMT_RESET_APP || b0 == `NMT_RESET_COMM);
    assign is_lss = rx_valid_i && state_o != ST_INIT && rx_frame_i.id == `LSS_REQ_ID
                    && rx_frame_i.dlc == `LSS_DLC;
    assign timer_start = is_lss && lss_config_o && b0 == `LSS_ACTIVATE;

    switch_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(timer_start),
        .delay_ms_i(b1),
        .done_o(timer_done)
    );

    // NMT state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_o <= ST_INIT;
            init_cnt_q <= 16'h0000;
            app_reset_o <= 1'b0;
            comm_reset_o <= 1'b0;
        end else begin
            app_reset_o <= 1'b0;
            comm_reset_o <= 1'b0;
            if (nmt_reset) begin
                state_o <= ST_INIT;
                init_cnt_q <= 16'h0000;
                app_reset_o <= (b0 == `NMT_RESET_APP);
                comm_reset_o <= (b0 == `NMT_RESET_COMM);
            end else if (state_o == ST_INIT) begin
                if (init_cnt_q == `INIT_CYCLES) begin
                    state_o <= ST_PREOP;
                end else begin
                    init_cnt_q <= init_cnt_q + 16'h0001;
                end
            end else if (nmt_for_me) begin
                unique case (b0)
                    `NMT_START: state_o <= ST_OPER;
                    `NMT_STOP: state_o <= ST_STOP;
                    `NMT_PREOP: state_o <= ST_PREOP;
                    default: state_o <= state_o;
                endcase
            end
        end
    end

    // Object enables follow the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_en_o <= '0;
        end else begin
            unique case (state_o)
                ST_INIT: comm_en_o <= '0;
                ST_PREOP: comm_en_o <= '{sdo_en: 1'b1, pdo_en: 1'b0, emcy_en: 1'b1,
                                         errctl_en: hb_enabled_i};
                ST_OPER: comm_en_o <= '{sdo_en: 1'b1, pdo_en: 1'b1, emcy_en: 1'b1,
                                        errctl_en: hb_enabled_i};
                ST_STOP: comm_en_o <= '{sdo_en: 1'b0, pdo_en: 1'b0, emcy_en: 1'b0,
                                        errctl_en: hb_enabled_i};
            endcase
        end
    end

    // Active id is only reloaded from storage in initialization, so a new id waits for a reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_q <= 1'b1;
            node_id_o <= 7'h7f;
            rate_idx_o <= 3'h0;
        end else begin
            load_q <= (state_o == ST_INIT) && !load_q ? 1'b1 : (state_o == ST_INIT);
            if (state_o == ST_INIT) begin
                node_id_o <= nv_cfg_i.node_id;
            end
            if (state_o == ST_INIT) begin
                rate_idx_o <= nv_cfg_i.rate_idx;
            end else if (timer_done) begin
                rate_idx_o <= pend_q.rate_idx;
            end
        end
    end

    // LSS mode, pending settings and replies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lss_config_o <= 1'b0;
            pend_q <= '{node_id: 7'h7f, rate_idx: 3'h0};
            tx_valid_o <= 1'b0;
            tx_frame_o <= '0;
            nv_write_o <= 1'b0;
            nv_wdata_o <= '0;
        end else begin
            if (tx_valid_o && tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end
            if (state_o == ST_INIT && load_q) begin
                pend_q <= nv_cfg_i;
            end
            if (nv_write_o && (nv_done_i || nv_fail_i)) begin
                nv_write_o <= 1'b0;
                tx_valid_o <= 1'b1;
                tx_frame_o <= '{id: `LSS_RSP_ID, dlc: `LSS_DLC,
                                data: {48'h0, (nv_fail_i ? `LSS_ERR_STORE : `LSS_OK), `LSS_STORE}};
            end
            if (is_lss) begin
                if (b0 == `LSS_SWITCH_MODE) begin
                    if (b1 == `LSS_MODE_CONFIG) begin
                        lss_config_o <= 1'b1;
                    end else if (b1 == `LSS_MODE_WAIT) begin
                        lss_config_o <= 1'b0;
                    end
                end else if (lss_config_o) begin
                    if (b0 == `LSS_SET_ID) begin
                        tx_valid_o <= 1'b1;
                        if (b1 >= `NODE_ID_MIN && b1 <= `NODE_ID_MAX) begin
                            pend_q.node_id <= b1[6:0];
                            tx_frame_o <= '{id: `LSS_RSP_ID, dlc: `LSS_DLC,
                                            data: {48'h0, `LSS_OK, `LSS_SET_ID}};
                        end else begin
                            tx_frame_o <= '{id: `LSS_RSP_ID, dlc: `LSS_DLC,
                                            data: {48'h0, `LSS_ERR_RANGE, `LSS_SET_ID}};
                        end
                    end else if (b0 == `LSS_SET_RATE) begin
                        tx_valid_o <= 1'b1;
                        if (b1 == `LSS_RATE_TABLE && b2 <= `LSS_RATE_MAX) begin
                            pend_q.rate_idx <= b2[2:0];
                            tx_frame_o <= '{id: `LSS_RSP_ID, dlc: `LSS_DLC,
                                            data: {48'h0, `LSS_OK, `LSS_SET_RATE}};
                        end else begin
                            tx_frame_o <= '{id: `LSS_RSP_ID, dlc: `LSS_DLC,
                                            data: {48'h0, `LSS_ERR_RANGE, `LSS_SET_RATE}};
                        end
                    end else if (b0 == `LSS_STORE && !nv_write_o) begin
                        nv_write_o <= 1'b1;
                        nv_wdata_o <= pend_q;
                    end
                end
            end
        end
    end
endmodule // nmt_lss_node_handler

// ==== pkg/nmt_lss_params.svh ====
`ifndef NMT_LSS_PARAMS_SVH
`define NMT_LSS_PARAMS_SVH

`define NMT_ID 11'h000
`define LSS_REQ_ID 11'h7e5
`define LSS_RSP_ID 11'h7e4
`define NMT_DLC 4'h2
`define LSS_DLC 4'h8
`define NMT_START 8'h01
`define NMT_STOP 8'h02
`define NMT_PREOP 8'h80
`define NMT_RESET_APP 8'h81
`define NMT_RESET_COMM 8'h82
`define NMT_ALL_NODES 8'h00
`define NODE_ID_MIN 8'h01
`define NODE_ID_MAX 8'h7f
`define LSS_SWITCH_MODE 8'h04
`define LSS_MODE_CONFIG 8'h01
`define LSS_MODE_WAIT 8'h00
`define LSS_SET_ID 8'h11
`define LSS_SET_RATE 8'h13
`define LSS_ACTIVATE 8'h15
`define LSS_STORE 8'h17
`define LSS_RATE_TABLE 8'h00
`define LSS_RATE_MAX 8'h04
`define LSS_OK 8'h00
`define LSS_ERR_RANGE 8'h01
`define LSS_ERR_STORE 8'h02
`define DELAY_FACTOR 2
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define CYCLES_PER_MS (`CLK_HZ / `MS_PER_S)
`define INIT_CYCLES 16'h0010

`endif

// ==== pkg/nmt_lss_pkg.sv ====
package nmt_lss_pkg;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_PREOP = 2'b01,
        ST_OPER = 2'b11,
        ST_STOP = 2'b10
    } nmt_state_type;

    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } can_frame_type;

    typedef struct packed {
        logic [6:0] node_id;
        logic [2:0] rate_idx;
    } layer_cfg_type;

    typedef struct packed {
        logic sdo_en;
        logic pdo_en;
        logic emcy_en;
        logic errctl_en;
    } comm_enable_type;
endpackage

// ==== rtl/frame_field.sv ====
`timescale 1ns/10ps
// Extracts one data byte from a frame payload (byte 0 in bits 7:0)
module frame_field #(
    parameter int INDEX = 0
) (
    input wire logic [63:0] data_i, // Frame payload
    output logic [7:0] byte_o // Selected byte
);
    assign byte_o = data_i[INDEX*8 +: 8];
endmodule // frame_field

// ==== rtl/switch_timer.sv ====
`timescale 1ns/10ps
`include "nmt_lss_params.svh"
// Counts a doubled millisecond delay, then pulses done_o
module switch_timer (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic start_i, // Load delay
    input wire logic [7:0] delay_ms_i, // Delay in ms
    output logic done_o // One-cycle pulse
);
    logic [8:0] ms_q;
    logic [15:0] tick_q;
    logic run_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            ms_q <= 9'h000;
            tick_q <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                run_q <= 1'b1;
                ms_q <= 9'({1'b0, delay_ms_i} * `DELAY_FACTOR);
                tick_q <= 16'h0000;
            end else if (run_q) begin
                if (ms_q == 9'h000) begin
                    run_q <= 1'b0;
                    done_o <= 1'b1;
                end else if (tick_q == 16'(`CYCLES_PER_MS - 1)) begin
                    tick_q <= 16'h0000;
                    ms_q <= ms_q - 9'h001;
                end else begin
                    tick_q <= tick_q + 16'h0001;
                end
            end
        end
    end
endmodule // switch_timer

// ==== verification/nmt_lss_node_handler_properties.sv ====
`timescale 1ns/10ps
module nmt_lss_node_handler_properties
    import nmt_lss_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic rx_valid_i, // Frame strobe
    input wire nmt_lss_pkg::can_frame_type rx_frame_i, // Received frame
    input wire logic tx_valid_o, // Reply pending
    input wire nmt_lss_pkg::can_frame_type tx_frame_o, // Reply frame
    input wire nmt_lss_pkg::nmt_state_type state_o, // State
    input wire nmt_lss_pkg::comm_enable_type comm_en_o, // Enables
    input wire logic [6:0] node_id_o, // Active node id
    input wire logic app_reset_o, // Application reset
    input wire logic comm_reset_o, // Communication reset
    input wire logic lss_config_o // Configuration flag
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic live, mine, nmt, lss;
    logic [7:0] cmd, arg;
    assign cmd = rx_frame_i.data[7:0];
    assign arg = rx_frame_i.data[15:8];
    // Frames arriving during initialization must leave no trace
    assign live = rx_valid_i && state_o != ST_INIT;
    assign mine = arg == 8'h00 || arg == {1'b0, node_id_o};
    assign nmt = live && rx_frame_i.id == 11'h000 && rx_frame_i.dlc == 4'h2 && mine;
    assign lss = live && rx_frame_i.id == 11'h7e5 && rx_frame_i.dlc == 4'h8;
    a_start_oper: assert property (nmt && cmd == 8'h01 |=> state_o == ST_OPER)
        else $error("start did not reach operational");
    a_stop_cmd: assert property (nmt && cmd == 8'h02 |=> state_o == ST_STOP)
        else $error("stop did not reach stopped");
    a_app_reset: assert property (nmt && cmd == 8'h81 |=> app_reset_o && state_o == ST_INIT)
        else $error("application reset missing");
    a_comm_reset: assert property (nmt && cmd == 8'h82 |=> comm_reset_o && state_o == ST_INIT)
        else $error("communication reset missing");
    a_init_leave: assert property (state_o == ST_INIT |-> ##[1:20] state_o == ST_PREOP)
        else $error("initialization did not end");
    a_foreign_skip: assert property (live && rx_frame_i.id == 11'h000
        && !(rx_frame_i.dlc == 4'h2 && mine) |=> $stable(state_o))
        else $error("foreign frame changed state");
    a_lss_locked: assert property (lss && !lss_config_o && cmd != 8'h04 && !tx_valid_o |=> !tx_valid_o)
        else $error("reply while waiting");
    a_lss_enter: assert property (lss && cmd == 8'h04 && arg == 8'h01 |=> lss_config_o)
        else $error("configuration not entered");
    a_id_reply: assert property (lss && lss_config_o && cmd == 8'h11
        |=> tx_valid_o && tx_frame_o.id == 11'h7e4
        && tx_frame_o.data[15:0] == {(arg >= 8'h01 && arg <= 8'h7f) ? 8'h00 : 8'h01, 8'h11})
        else $error("node id reply wrong");
    a_preop_enables: assert property (state_o == ST_PREOP && $past(state_o) == ST_PREOP
        |-> comm_en_o.sdo_en && !comm_en_o.pdo_en && comm_en_o.emcy_en)
        else $error("pre-operational enables wrong");
endmodule // nmt_lss_node_handler_properties

// ==== verification/can_master_model.sv ====
`timescale 1ns/10ps
module can_master_model (
    input wire logic clk_i, // Clock
    input wire logic fail_i, // Make the next store fail
    input wire logic reply_valid_i, // Reply pending
    output logic reply_ready_o, // Reply taken
    input wire logic store_i, // Store request
    input wire logic [9:0] store_data_i, // Data to store
    output logic store_done_o, // Store finished
    output logic store_fail_o, // Store failed
    output logic [9:0] stored_o // Memory contents
);
    logic [1:0] wait_q;
    initial begin
        reply_ready_o = 1'b0;
        store_done_o = 1'b0;
        store_fail_o = 1'b0;
        wait_q = 2'h0;
        stored_o = {7'h05, 3'h1};
    end
    // Bus arbitration delays every reply by a cycle
    always @(posedge clk_i) reply_ready_o <= reply_valid_i && !reply_ready_o;
    // A failed store keeps the old contents
    always @(posedge clk_i) begin
        store_done_o <= 1'b0;
        store_fail_o <= 1'b0;
        if (store_i && !store_done_o && !store_fail_o) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == 2'h3) begin
                store_fail_o <= fail_i;
                store_done_o <= !fail_i;
                if (!fail_i) stored_o <= store_data_i;
            end
        end else wait_q <= 2'h0;
    end
endmodule // can_master_model

// ==== verification/nmt_lss_node_handler_test.sv ====
`timescale 1ns/10ps
module nmt_lss_node_handler_test;
    import nmt_lss_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0, fail = 1'b0, hb_en = 1'b1, tx_ready_i, nv_done_i, nv_fail_i;
    logic tx_valid_o, nv_write_o, app_reset_o, comm_reset_o, lss_config_o;
    can_frame_type rx_frame_i = '0, tx_frame_o;
    layer_cfg_type nv_cfg_i, nv_wdata_o;
    nmt_state_type state_o;
    comm_enable_type comm_en_o;
    logic [6:0] node_id_o;
    logic [2:0] rate_idx_o;
    int num_errors = 0, n_compared = 0, i;
    nmt_lss_node_handler DUT (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
        .tx_ready_i(tx_ready_i), .nv_cfg_i(nv_cfg_i), .nv_done_i(nv_done_i), .nv_fail_i(nv_fail_i),
        .hb_enabled_i(hb_en), .tx_frame_o(tx_frame_o), .tx_valid_o(tx_valid_o), .state_o(state_o),
        .comm_en_o(comm_en_o), .node_id_o(node_id_o), .rate_idx_o(rate_idx_o), .nv_write_o(nv_write_o),
        .nv_wdata_o(nv_wdata_o), .app_reset_o(app_reset_o), .comm_reset_o(comm_reset_o),
        .lss_config_o(lss_config_o));
    can_master_model master (.clk_i(clk_i), .fail_i(fail), .reply_valid_i(tx_valid_o), .reply_ready_o(tx_ready_i),
        .store_i(nv_write_o), .store_data_i(nv_wdata_o), .store_done_o(nv_done_i), .store_fail_o(nv_fail_i),
        .stored_o(nv_cfg_i));
    initial forever #25 clk_i = ~clk_i;
    task finish_test;
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] b0, b1, b2);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_frame_i <= {id, dlc, 40'h0, b2, b1, b0};
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        #1;
    endtask
    task lss(input logic [7:0] c, a, b);
        send(11'h7e5, 4'h8, c, a, b);
    endtask
    task reply(input logic [15:0] e);
        for (i = 0; i < 20 && tx_valid_o !== 1'b1; i++) @(posedge clk_i) #1;
        // A missing reply must not pass on a stale frame from the previous command
        chk("reply valid", 16'h0001, tx_valid_o);
        chk("reply id", 16'h7e48, {1'b0, tx_frame_o.id, tx_frame_o.dlc});
        chk("reply", e, tx_frame_o.data[15:0]);
        repeat (3) @(posedge clk_i);
    endtask
    task wait_preop;
        for (i = 0; i < 20 && state_o !== ST_PREOP; i++) @(posedge clk_i) #1;
        chk("state", ST_PREOP, state_o);
        @(posedge clk_i) #1;
    endtask
    task t_init;
        chk("state", ST_INIT, state_o);
        wait_preop();
        chk("node id", 16'h0005, node_id_o);
        chk("enables", 3'b101, comm_en_o[3:1]);
    endtask
    task t_nmt;
        send(11'h000, 4'h2, 8'h01, 8'h06, 8'h00);
        send(11'h000, 4'h3, 8'h01, 8'h05, 8'h00);
        chk("state", ST_PREOP, state_o);
        send(11'h000, 4'h2, 8'h01, 8'h05, 8'h00);
        chk("state", ST_OPER, state_o);
        @(posedge clk_i) #1;
        chk("enables", 4'hf, comm_en_o);
        send(11'h000, 4'h2, 8'h02, 8'h00, 8'h00);
        chk("state", ST_STOP, state_o);
        @(posedge clk_i) #1;
        chk("enables", 4'h1, comm_en_o);
        @(posedge clk_i);
        hb_en <= 1'b0;
        @(posedge clk_i) #1;
        chk("enables", 16'h0000, comm_en_o);
        @(posedge clk_i);
        hb_en <= 1'b1;
        send(11'h000, 4'h2, 8'h80, 8'h05, 8'h00);
        chk("state", ST_PREOP, state_o);
        send(11'h000, 4'h2, 8'h81, 8'h05, 8'h00);
        chk("app reset", 16'h0004, {app_reset_o, state_o});
        wait_preop();
        send(11'h000, 4'h2, 8'h82, 8'h00, 8'h00);
        chk("comm reset", 16'h0004, {comm_reset_o, state_o});
        wait_preop();
    endtask
    task t_lss;
        lss(8'h11, 8'h09, 8'h00);
        repeat (2) @(posedge clk_i) #1;
        chk("reply valid", 16'h0000, tx_valid_o);
        lss(8'h04, 8'h01, 8'h00);
        chk("config", 16'h0001, lss_config_o);
        @(posedge clk_i) #1;
        chk("reply valid", 16'h0000, tx_valid_o);
        lss(8'h11, 8'h80, 8'h00);
        reply(16'h0111);
        lss(8'h11, 8'h0a, 8'h00);
        reply(16'h0011);
        for (int r = 0; r < 6; r++) begin
            lss(8'h13, 8'h00, 8'(r));
            reply(r < 5 ? 16'h0013 : 16'h0113);
        end
        fail <= 1'b1;
        lss(8'h17, 8'h00, 8'h00);
        reply(16'h0217);
        fail <= 1'b0;
        lss(8'h17, 8'h00, 8'h00);
        chk("store request", 16'h0001, nv_write_o);
        chk("store data", 16'h0054, nv_wdata_o);
        reply(16'h0017);
        lss(8'h15, 8'h01, 8'h00);
        // One millisecond doubled is 40000 cycles at this clock
        repeat (39000) @(posedge clk_i);
        #1;
        chk("rate", 16'h0001, rate_idx_o);
        for (i = 0; i < 2000 && rate_idx_o !== 3'h4; i++) @(posedge clk_i) #1;
        chk("rate", 16'h0004, rate_idx_o);
        lss(8'h04, 8'h00, 8'h00);
        chk("config", 16'h0000, lss_config_o);
        @(posedge clk_i) #1;
        chk("reply valid", 16'h0000, tx_valid_o);
        send(11'h000, 4'h2, 8'h81, 8'h05, 8'h00);
        wait_preop();
        chk("node id", 16'h000a, node_id_o);
        chk("rate", 16'h0004, rate_idx_o);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i) #1;
        t_init();
        t_nmt();
        t_lss();
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end
endmodule // nmt_lss_node_handler_test
bind nmt_lss_node_handler nmt_lss_node_handler_properties checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame_o),
    .state_o(state_o), .comm_en_o(comm_en_o), .node_id_o(node_id_o), .app_reset_o(app_reset_o),
    .comm_reset_o(comm_reset_o), .lss_config_o(lss_config_o));
